// >>> common/target_image_pkg.sv
`default_nettype none
package target_image_pkg;
  localparam int num_images = 2;
  // Register byte addresses
  localparam logic [8:0] off_image0_control = 9'h100;
  localparam logic [8:0] off_image0_address = 9'h104;
  localparam logic [8:0] off_image1_control = 9'h110;
  localparam logic [8:0] off_image1_address = 9'h114;
  // Control register field positions
  localparam int pos_enable = 31;
  localparam int pos_block_size = 24;
  localparam int pos_prefetch = 23;
  localparam int pos_burst = 22;
  localparam int pos_endian = 20;
  localparam int pos_tcode = 12;
  localparam int pos_dest_port_size = 10;
  localparam int pos_posted = 7;
  localparam int pos_space = 6;
  // Address register field positions
  localparam int pos_base = 16;
  localparam int pos_trans = 0;
  // Field widths and reset values
  localparam int bs_w = 4;
  localparam int tc_w = 4;
  localparam int ds_w = 2;
  localparam int half_w = 16;
  localparam logic [bs_w-1:0] bs_reset = 4'h0;
  localparam logic [tc_w-1:0] tc_reset = 4'h0;
  localparam logic [ds_w-1:0] ds_reset = 2'h0;
  localparam logic [half_w-1:0] half_reset = 16'h0000;
  // Port size codes
  localparam logic [ds_w-1:0] dest_port_size_32 = 2'h0;
  localparam logic [ds_w-1:0] dest_port_size_8 = 2'h1;
  localparam logic [ds_w-1:0] dest_port_size_16 = 2'h2;
  // Address space codes
  localparam logic space_memory = 1'b0;
  localparam logic space_io = 1'b1;
endpackage : target_image_pkg
`default_nettype wire

// >>> logic/image_match.sv
`default_nettype none
module image_match
  import target_image_pkg::*;
(
  input wire logic enable,
  input wire logic [bs_w-1:0] block_size,
  input wire logic space,
  input wire logic [half_w-1:0] base,
  input wire logic [half_w-1:0] translation_address,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  output logic hit,
  output logic [31:0] local_addr
);

  // Ones over the compared lines, AD31 down to AD(16+bs)
  function automatic logic [half_w-1:0] compare_mask(
    input logic [bs_w-1:0] bs
  );
    logic [half_w-1:0] m;
    m = '1;
    compare_mask = m << bs;
  endfunction : compare_mask

  logic [half_w-1:0] mask;
  logic [half_w-1:0] upper;

  always_comb begin
    mask = compare_mask(block_size);
    upper = pci_addr[31:16];
    hit = enable && (pci_io == space) &&
      ((upper & mask) == (base & mask));
    local_addr = {(translation_address & mask) | (upper & ~mask),
      pci_addr[15:0]};
  end

endmodule : image_match
`default_nettype wire

// >>> logic/target_image_decode.sv
`default_nettype none
module target_image_decode
  import target_image_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pci_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  // Power-up and preload information
  input wire logic eeprom_loaded,
  input wire logic [num_images-1:0] eeprom_bar_enable,
  input wire logic [bs_w*num_images-1:0] eeprom_block_size,
  input wire logic pci_disable_strap,
  // PCI base address registers, kept elsewhere
  input wire logic [half_w*num_images-1:0] pci_bar_base,
  input wire logic [num_images-1:0] pci_bar_space,
  output logic [num_images-1:0] pci_bar_enable,
  // Global byte order from misc_control
  input wire logic local_byte_order,
  // PCI address phase
  input wire logic addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  input wire logic pci_write,
  input wire logic pci_burst,
  // Forwarded access
  output logic fwd_valid,
  output logic [num_images-1:0] fwd_hit,
  output logic [31:0] fwd_addr,
  output logic [tc_w-1:0] fwd_tcode,
  output logic [ds_w-1:0] fwd_dest_port_size,
  output logic fwd_byte_order,
  output logic fwd_prefetch,
  output logic fwd_burst_write,
  output logic fwd_posted
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage, general reset group
  logic [num_images-1:0] en, next_en;
  logic [num_images-1:0] prefetch_read_enable, next_prefetch_read_enable;
  logic [num_images-1:0] bwen, next_bwen;
  logic [num_images-1:0] inv, next_inv;
  logic [num_images-1:0] posted_write_enable, next_posted_write_enable;
  logic [tc_w-1:0] tcode [num_images];
  logic [tc_w-1:0] next_tcode [num_images];
  logic [ds_w-1:0] dest_port_size [num_images];
  logic [ds_w-1:0] next_dest_port_size [num_images];
  logic [half_w-1:0] trans [num_images];
  logic [half_w-1:0] next_trans [num_images];

  // Storage, PCI reset group
  logic [bs_w-1:0] bsize [num_images];
  logic [bs_w-1:0] next_bsize [num_images];
  logic [num_images-1:0] space, next_space;
  logic [half_w-1:0] base [num_images];
  logic [half_w-1:0] next_base [num_images];
  logic capture, next_capture;
  logic preload, next_preload;
  logic disable_latched, next_disable_latched;
  logic [num_images-1:0] bar_on, next_bar_on;

  // Effective views seen by decode and readback
  logic [num_images-1:0] space_eff;
  logic [half_w-1:0] base_eff [num_images];
  logic [num_images-1:0] shape_locked;

  function automatic logic is_ctl(input logic [8:0] a, input int i);
    is_ctl = (i == 0) ? (a == off_image0_control)
                      : (a == off_image1_control);
  endfunction : is_ctl

  function automatic logic is_adr(input logic [8:0] a, input int i);
    is_adr = (i == 0) ? (a == off_image0_address)
                      : (a == off_image1_address);
  endfunction : is_adr

  ////////////////////////////////////////////////////////////////////////////
  // Per-image register next values
  genvar gi;
  generate
    for (gi = 0; gi < num_images; gi++) begin : g_img
      always_comb begin
        shape_locked[gi] = preload && !disable_latched;
        // Locked space follows the BAR's own bit
        space_eff[gi] = shape_locked[gi] ? pci_bar_space[gi]
                                         : space[gi];
        base_eff[gi] = bar_on[gi]
          ? pci_bar_base[half_w*gi +: half_w] : base[gi];
      end

      always_comb begin
        next_en[gi] = en[gi];
        next_prefetch_read_enable[gi] = prefetch_read_enable[gi];
        next_bwen[gi] = bwen[gi];
        next_inv[gi] = inv[gi];
        next_posted_write_enable[gi] = posted_write_enable[gi];
        next_tcode[gi] = tcode[gi];
        next_dest_port_size[gi] = dest_port_size[gi];
        next_trans[gi] = trans[gi];
        if (reg_wr && is_ctl(reg_addr, gi)) begin
          next_en[gi] = reg_wdata[pos_enable];
          next_prefetch_read_enable[gi] = reg_wdata[pos_prefetch];
          next_bwen[gi] = reg_wdata[pos_burst];
          next_inv[gi] = reg_wdata[pos_endian];
          next_posted_write_enable[gi] = reg_wdata[pos_posted];
          next_tcode[gi] = reg_wdata[pos_tcode +: tc_w];
          next_dest_port_size[gi] = reg_wdata[pos_dest_port_size +: ds_w];
        end
        if (reg_wr && is_adr(reg_addr, gi)) begin
          next_trans[gi] = reg_wdata[pos_trans +: half_w];
        end
      end

      always_comb begin
        next_bsize[gi] = bsize[gi];
        next_space[gi] = space[gi];
        next_base[gi] = base[gi];
        if (capture) begin
          // Preload arrives once, just after PCI reset lets go
          if (eeprom_loaded) begin
            next_bsize[gi] = eeprom_block_size[bs_w*gi +: bs_w];
            next_space[gi] = pci_bar_space[gi];
          end
        end else begin
          if (reg_wr && is_ctl(reg_addr, gi) && !shape_locked[gi]) begin
            next_bsize[gi] = reg_wdata[pos_block_size +: bs_w];
            next_space[gi] = reg_wdata[pos_space];
          end
          if (reg_wr && is_adr(reg_addr, gi) && !bar_on[gi]) begin
            next_base[gi] = reg_wdata[pos_base +: half_w];
          end
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          en[gi] <= 1'b0;
          prefetch_read_enable[gi] <= 1'b0;
          bwen[gi] <= 1'b0;
          inv[gi] <= 1'b0;
          posted_write_enable[gi] <= 1'b0;
          tcode[gi] <= tc_reset;
          dest_port_size[gi] <= ds_reset;
          trans[gi] <= half_reset;
        end else begin
          en[gi] <= next_en[gi];
          prefetch_read_enable[gi] <= next_prefetch_read_enable[gi];
          bwen[gi] <= next_bwen[gi];
          inv[gi] <= next_inv[gi];
          posted_write_enable[gi] <= next_posted_write_enable[gi];
          tcode[gi] <= next_tcode[gi];
          dest_port_size[gi] <= next_dest_port_size[gi];
          trans[gi] <= next_trans[gi];
        end
      end

      always_ff @(posedge clk or posedge pci_rst) begin
        if (pci_rst) begin
          bsize[gi] <= bs_reset;
          space[gi] <= space_memory;
          base[gi] <= half_reset;
        end else begin
          bsize[gi] <= next_bsize[gi];
          space[gi] <= next_space[gi];
          base[gi] <= next_base[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strap and preload capture after PCI reset release
  always_comb begin
    next_capture = 1'b0;
    next_preload = preload;
    next_disable_latched = disable_latched;
    next_bar_on = bar_on;
    if (capture) begin
      next_preload = eeprom_loaded;
      next_disable_latched = pci_disable_strap;
      // No preload means the BAR cannot be enabled by the EEPROM
      next_bar_on = ({num_images{eeprom_loaded}} & eeprom_bar_enable)
        | {num_images{pci_disable_strap}};
    end
  end

  always_ff @(posedge clk or posedge pci_rst) begin
    if (pci_rst) begin
      capture <= 1'b1;
      preload <= 1'b0;
      disable_latched <= 1'b0;
      bar_on <= '0;
    end else begin
      capture <= next_capture;
      preload <= next_preload;
      disable_latched <= next_disable_latched;
      bar_on <= next_bar_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback
  logic [31:0] next_rdata;
  logic next_rd_valid;
  logic [num_images-1:0] next_bar_enable;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rd_valid = reg_rd;
    next_bar_enable = bar_on;
    for (int i = 0; i < num_images; i++) begin
      if (is_ctl(reg_addr, i)) begin
        next_rdata[pos_enable] = en[i];
        next_rdata[pos_block_size +: bs_w] = bsize[i];
        next_rdata[pos_prefetch] = prefetch_read_enable[i];
        next_rdata[pos_burst] = bwen[i];
        next_rdata[pos_endian] = inv[i];
        next_rdata[pos_tcode +: tc_w] = tcode[i];
        next_rdata[pos_dest_port_size +: ds_w] = dest_port_size[i];
        next_rdata[pos_posted] = posted_write_enable[i];
        next_rdata[pos_space] = space_eff[i];
      end
      if (is_adr(reg_addr, i)) begin
        next_rdata[pos_base +: half_w] = base_eff[i];
        next_rdata[pos_trans +: half_w] = trans[i];
      end
    end
    if (!reg_rd) begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rd_valid <= 1'b0;
      pci_bar_enable <= '0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rd_valid <= next_rd_valid;
      pci_bar_enable <= next_bar_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode
  logic [num_images-1:0] hit;
  logic [31:0] xaddr [num_images];

  generate
    for (gi = 0; gi < num_images; gi++) begin : g_match
      image_match u_match (
        .enable(en[gi]),
        .block_size(bsize[gi]),
        .space(space_eff[gi]),
        .base(base_eff[gi]),
        .translation_address(trans[gi]),
        .pci_addr(pci_addr),
        .pci_io(pci_io),
        .hit(hit[gi]),
        .local_addr(xaddr[gi])
      );
    end
  endgenerate

  logic next_valid;
  logic [num_images-1:0] next_hit;
  logic [31:0] next_addr;
  logic [tc_w-1:0] next_tc;
  logic [ds_w-1:0] next_ds;
  logic next_order, next_prefetch, next_burst, next_posted;
  int sel;

  always_comb begin
    // Overlapping images: image 0 takes precedence
    sel = hit[0] ? 0 : 1;
    next_hit = addr_valid ? hit : '0;
    next_valid = addr_valid && (hit != '0);
    next_addr = 32'h0000_0000;
    next_tc = tc_reset;
    next_ds = ds_reset;
    next_order = 1'b0;
    next_prefetch = 1'b0;
    next_burst = 1'b0;
    next_posted = 1'b0;
    if (next_valid) begin
      next_addr = xaddr[sel];
      next_tc = tcode[sel];
      next_ds = dest_port_size[sel];
      next_order = local_byte_order ^ inv[sel];
      next_prefetch = prefetch_read_enable[sel] && !pci_write;
      next_burst = bwen[sel] && pci_write && pci_burst;
      next_posted = posted_write_enable[sel] && pci_write && !pci_io;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_hit <= '0;
      fwd_addr <= 32'h0000_0000;
      fwd_tcode <= tc_reset;
      fwd_dest_port_size <= ds_reset;
      fwd_byte_order <= 1'b0;
      fwd_prefetch <= 1'b0;
      fwd_burst_write <= 1'b0;
      fwd_posted <= 1'b0;
    end else begin
      fwd_valid <= next_valid;
      fwd_hit <= next_hit;
      fwd_addr <= next_addr;
      fwd_tcode <= next_tc;
      fwd_dest_port_size <= next_ds;
      fwd_byte_order <= next_order;
      fwd_prefetch <= next_prefetch;
      fwd_burst_write <= next_burst;
      fwd_posted <= next_posted;
    end
  end

endmodule : target_image_decode
`default_nettype wire

// >>> tb/image_decode_props.sv
`default_nettype none
module image_decode_props
  import target_image_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic addr_valid,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  input wire logic pci_write,
  input wire logic pci_burst,
  input wire logic fwd_valid,
  input wire logic [num_images-1:0] fwd_hit,
  input wire logic [31:0] fwd_addr,
  input wire logic [tc_w-1:0] fwd_tcode,
  input wire logic fwd_prefetch,
  input wire logic fwd_burst_write,
  input wire logic fwd_posted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_claim;
    addr_valid ##1 fwd_valid;
  endsequence
  a_read_answer: assert property (reg_rd |=> reg_rd_valid)
    else $error("read not answered next cycle");
  a_rdata_idle: assert property (!reg_rd_valid |-> reg_rdata == 32'h0)
    else $error("read data not zero while idle");
  a_claim_cause: assert property (
    fwd_valid |-> $past(addr_valid) && fwd_hit != 0)
    else $error("claim without address phase or hit");
  a_idle_quiet: assert property (
    !fwd_valid |-> fwd_addr == 0 && fwd_hit == 0)
    else $error("forward fields not zero while idle");
  a_lower_kept: assert property (
    s_claim |-> fwd_addr[15:0] == $past(pci_addr[15:0]))
    else $error("lower address lines altered");
  a_posted_memory: assert property (
    s_claim |-> !(fwd_posted && $past(pci_io)))
    else $error("io write posted");
  a_prefetch_read: assert property (
    fwd_prefetch |-> !$past(pci_write))
    else $error("prefetch on write");
  a_burst_cause: assert property (
    fwd_burst_write |-> $past(pci_write && pci_burst))
    else $error("burst flag without burst write");
  a_tcode_idle: assert property (!fwd_valid |-> fwd_tcode == 0)
    else $error("transaction code while idle");
endmodule : image_decode_props
bind target_image_decode image_decode_props u_props (.clk(clk), .rst(rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .addr_valid(addr_valid), .pci_addr(pci_addr), .pci_io(pci_io),
  .pci_write(pci_write), .pci_burst(pci_burst), .fwd_valid(fwd_valid),
  .fwd_hit(fwd_hit), .fwd_addr(fwd_addr), .fwd_tcode(fwd_tcode),
  .fwd_prefetch(fwd_prefetch), .fwd_burst_write(fwd_burst_write),
  .fwd_posted(fwd_posted));
`default_nettype wire

// >>> tb/pci_master_model.sv
`default_nettype none
module pci_master_model (
  input wire logic clk,
  output logic addr_valid,
  output logic [31:0] pci_addr,
  output logic pci_io,
  output logic pci_write,
  output logic pci_burst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_valid = 1'b0;
    pci_addr = 32'h0;
    pci_io = 1'b0;
    pci_write = 1'b0;
    pci_burst = 1'b0;
  end
  // One address phase; address lines inverted after and addr_valid dropped, so stale values are never claimed
  task automatic phase(input logic [31:0] a, input logic io, wr, bu);
    @(posedge clk);
    addr_valid <= 1'b1;
    pci_addr <= a;
    pci_io <= io;
    pci_write <= wr;
    pci_burst <= bu;
    @(posedge clk);
    addr_valid <= 1'b0;
    pci_addr <= ~a;
  endtask : phase
endmodule : pci_master_model
`default_nettype wire

// >>> tb/tb_pci_target_image_decode.sv
`default_nettype none
module tb_pci_target_image_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import target_image_pkg::*;
  logic clk, rst, pci_rst, reg_wr, reg_rd, reg_rd_valid, ld, strap, lbo;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, bar_base, pci_addr, fwd_addr;
  logic [1:0] bar_en, bar_sp, bar_on, fwd_hit, fwd_dest_port_size;
  logic [7:0] ee_bs;
  logic addr_valid, pci_io, pci_write, pci_burst, fwd_valid, fwd_bo;
  logic fwd_prefetch, fwd_burst_write, fwd_posted;
  logic [3:0] fwd_tcode;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] cm;
  ////////////////////////////////////////////////////////////////////////
  target_image_decode u_dut (.clk(clk), .rst(rst), .pci_rst(pci_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .eeprom_loaded(ld),
    .eeprom_bar_enable(bar_en), .eeprom_block_size(ee_bs),
    .pci_disable_strap(strap), .pci_bar_base(bar_base),
    .pci_bar_space(bar_sp), .pci_bar_enable(bar_on),
    .local_byte_order(lbo), .addr_valid(addr_valid), .pci_addr(pci_addr),
    .pci_io(pci_io), .pci_write(pci_write), .pci_burst(pci_burst),
    .fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .fwd_addr(fwd_addr),
    .fwd_tcode(fwd_tcode), .fwd_dest_port_size(fwd_dest_port_size), .fwd_byte_order(fwd_bo),
    .fwd_prefetch(fwd_prefetch), .fwd_burst_write(fwd_burst_write),
    .fwd_posted(fwd_posted));
  pci_master_model u_m (.clk(clk), .addr_valid(addr_valid),
    .pci_addr(pci_addr), .pci_io(pci_io), .pci_write(pci_write),
    .pci_burst(pci_burst));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctrl(input logic en, input logic [3:0] bs,
      input logic pf, bw, ei, input logic [3:0] tc, input logic [1:0] ds,
      input logic pw, sp);
    return (32'(en) << pos_enable) | (32'(bs) << pos_block_size) |
      (32'(pf) << pos_prefetch) | (32'(bw) << pos_burst) |
      (32'(ei) << pos_endian) | (32'(tc) << pos_tcode) |
      (32'(ds) << pos_dest_port_size) | (32'(pw) << pos_posted) |
      (32'(sp) << pos_space);
  endfunction : ctrl
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [31:0] e, m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp("reg_rd_valid", 32'h1, 32'(reg_rd_valid));
    cmp("reg_rdata", e & m, reg_rdata & m);
  endtask : rd
  task automatic fwd(input logic [31:0] a, input logic io, w, b, v,
      input logic [1:0] h, input logic [31:0] fa);
    u_m.phase(a, io, w, b);
    #1;
    cmp("fwd_valid", 32'(v), 32'(fwd_valid));
    cmp("fwd_hit", 32'(h), 32'(fwd_hit));
    cmp("fwd_addr", fa, fwd_addr);
  endtask : fwd
  task automatic pulse_pci;
    pci_rst <= 1'b1;
    repeat (2) @(posedge clk);
    pci_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse_pci
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial begin
    {rst, pci_rst, reg_wr, reg_rd, ld, strap, lbo} = 7'h60;
    reg_addr = 9'h0;
    reg_wdata = 32'h0;
    {bar_en, bar_sp, ee_bs, bar_base} = 44'h0;
    cm = ctrl(1, 4'hf, 1, 1, 1, 4'hf, 2'h3, 1, 1);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    pci_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(off_image0_control, 32'h0, cm);
    rd(off_image0_address, 32'h0, '1);
    rd(off_image1_control, 32'h0, cm);
    rd(off_image1_address, 32'h0, '1);
    rd(9'h1fc, 32'h0, '1);
    cmp("pci_bar_enable", 32'h0, 32'(bar_on));
    // Translation differs from base, so a missed swap shows
    wr(off_image0_address, 32'h1234_abcd);
    wr(off_image0_control, ctrl(1, 0, 0, 0, 1, 4'ha, dest_port_size_8, 1, 0));
    rd(off_image0_address, 32'h1234_abcd, '1);
    fwd(32'h1234_5678, 0, 1, 0, 1, 2'b01, 32'habcd_5678);
    cmp("fwd_tcode", 32'ha, 32'(fwd_tcode));
    cmp("fwd_byte_order", 32'h1, 32'(fwd_bo));
    cmp("fwd_posted", 32'h1, 32'(fwd_posted));
    fwd(32'h1235_5678, 0, 0, 0, 0, 2'b00, 32'h0);
    fwd(32'h1234_5678, 1, 0, 0, 0, 2'b00, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(off_image0_control,
         ctrl(1, 0, k[0], k[0], k[0], 4'h0, k[1:0], 0, 0));
      lbo <= k[1];
      fwd(32'h1234_0010, 0, 0, 0, 1, 2'b01, 32'habcd_0010);
      cmp("fwd_dest_port_size", 32'(k), 32'(fwd_dest_port_size));
      cmp("fwd_byte_order", 32'(k[1] ^ k[0]), 32'(fwd_bo));
      cmp("fwd_prefetch", 32'(k[0]), 32'(fwd_prefetch));
      fwd(32'h1234_0020, 0, 1, 1, 1, 2'b01, 32'habcd_0020);
      cmp("fwd_burst_write", 32'(k[0]), 32'(fwd_burst_write));
    end
    // Identity mapping: translation equals base
    wr(off_image0_address, 32'h8000_8000);
    wr(off_image0_control, ctrl(1, 4'hf, 0, 0, 0, 0, 0, 1, 0));
    fwd(32'hffff_1234, 0, 0, 0, 1, 2'b01, 32'hffff_1234);
    fwd(32'h7fff_1234, 0, 0, 0, 0, 2'b00, 32'h0);
    wr(off_image0_control, ctrl(1, 4'hf, 0, 0, 0, 0, 0, 1, 1));
    fwd(32'h8000_0010, 1, 1, 0, 1, 2'b01, 32'h8000_0010);
    cmp("fwd_posted", 32'h0, 32'(fwd_posted));
    fwd(32'h8000_0010, 0, 1, 0, 0, 2'b00, 32'h0);
    wr(off_image0_control, ctrl(0, 4'hf, 0, 0, 0, 0, 0, 1, 1));
    fwd(32'h8000_0010, 1, 1, 0, 0, 2'b00, 32'h0);
    wr(off_image1_address, 32'h4000_2000);
    wr(off_image1_control, ctrl(1, 0, 0, 0, 0, 4'h5, 0, 0, 0));
    fwd(32'h4000_0004, 0, 0, 0, 1, 2'b10, 32'h2000_0004);
    cmp("fwd_tcode", 32'h5, 32'(fwd_tcode));
    // Preload locks size and space, bases mirror the outside registers
    {ld, bar_en, ee_bs, bar_sp} <= {1'b1, 2'h3, 8'h52, 2'h2};
    bar_base <= 32'h5555_6666;
    pulse_pci();
    cmp("pci_bar_enable", 32'h3, 32'(bar_on));
    rd(off_image1_control, ctrl(1, 5, 0, 0, 0, 5, 0, 0, 1), cm);
    wr(off_image1_control, ctrl(1, 0, 0, 0, 0, 5, 0, 0, 0));
    rd(off_image1_control, ctrl(1, 5, 0, 0, 0, 5, 0, 0, 1), cm);
    wr(off_image1_address, 32'h0000_2000);
    rd(off_image1_address, 32'h5555_2000, '1);
    rd(off_image0_address, 32'h6666_8000, '1);
    strap <= 1'b1;
    bar_en <= 2'b00;
    pulse_pci();
    wr(off_image0_control, ctrl(0, 3, 0, 0, 0, 0, 0, 0, 0));
    rd(off_image0_control, ctrl(0, 3, 0, 0, 0, 0, 0, 0, 0),
       ctrl(0, 4'hf, 0, 0, 0, 0, 0, 0, 0));
    rd(off_image0_address, 32'h6666_8000, '1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(off_image1_control, ctrl(0, 5, 0, 0, 0, 0, 0, 0, 0),
       ctrl(1, 4'hf, 0, 0, 0, 4'hf, 0, 0, 0));
    rd(off_image1_address, 32'h5555_0000, '1);
    wrap_up();
  end
endmodule : tb_pci_target_image_decode
`default_nettype wire
